// file: hdl/lftjp_pkg.sv
// package for the fault tally and jitter peak readout block
// used by the single design file; the bench and assertions use literal offsets
package lftjp_pkg;
  localparam int          ADDR_W          = 11;
  localparam logic [10:0] OFF_TALLY_LO_C1 = 11'h023;
  localparam logic [10:0] OFF_TALLY_HI_C1 = 11'h024;
  localparam logic [10:0] OFF_TALLY_LO_C0 = 11'h7E3;
  localparam logic [10:0] OFF_TALLY_HI_C0 = 11'h7E4;
  localparam logic [10:0] OFF_WANDER_CFG  = 11'h7E5;
  localparam logic [10:0] OFF_POS_LO      = 11'h7E6;
  localparam logic [10:0] OFF_POS_HI      = 11'h7E7;
  localparam logic [10:0] OFF_NEG_LO      = 11'h7E8;
  localparam logic [10:0] OFF_NEG_HI      = 11'h7E9;
  localparam logic [10:0] OFF_TALLY_CFG   = 11'h7F0;
  localparam logic [10:0] OFF_TALLY_SNAP  = 11'h7F1;
  localparam logic [10:0] OFF_IRQ_STAT    = 11'h7F2;
  localparam logic [10:0] OFF_IRQ_MASK    = 11'h7F3;
  localparam int BIT_BW        = 0;
  localparam int BIT_PERIOD    = 1;
  localparam int BIT_STOP      = 2;
  localparam int BIT_TALLY_MD  = 1;
  localparam int BIT_OV_C1     = 0;
  localparam int BIT_OV_C0     = 1;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_TALLY = 16'h0000;
  localparam logic [11:0] RST_PEAK  = 12'h000;
  localparam int CLK_HZ          = 100_000_000;
  localparam int PERIOD_S        = 1;
  localparam int PERIOD_CYC      = CLK_HZ * PERIOD_S;
  localparam int TALLY_ROUND_CYC = 100_000_000;

  typedef struct packed {
    logic        stop;
    logic        period;
    logic        bw;
  } lftjp_wcfg_t;

  typedef struct packed {
    logic [11:0] pos;
    logic [11:0] neg;
  } lftjp_peaks_t;
endpackage

// file: hdl/lftjp_core.sv
// fault tally and channel-0 jitter peak readout, one clock domain
// assumes fault pulses and jitter samples are synchronous to sys_clk
//
// Operation
// - 16-bit tally split low/high bytes, read-only
// - separate tally pair for channel 0
// - tally mode bit picks auto/manual update
// - held tally overwritten by next round
// - period bit: manual stop or one second
// - stop bit honoured only in manual mode
// - stop rising edge loads both peak pairs
// - bandwidth 0 selects wide band filter
// - bandwidth 1 selects high-pass band filter
// - 12-bit positive peak, upper nibble reserved
// - positive peak in sixteenths of UI
// - peaks update per period mode, read next round
// - negative peak pair, same period rules
// - tally overflow sets sticky interrupt flag
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module lftjp_core #(
  parameter int TALLY_ROUND = lftjp_pkg::TALLY_ROUND_CYC,
  parameter int JIT_PERIOD  = lftjp_pkg::PERIOD_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  input  wire logic [10:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              fault_c0,
  input  wire logic              fault_c1,
  input  wire logic              e1_mode,
  input  wire logic signed [11:0] jit_wide,
  input  wire logic signed [11:0] jit_high,
  output logic                   bandwidth_select,
  output logic                   irq
);
  // pkg shorthand avoided; every use written in full

  // config, tallies, peaks, interrupt state
  lftjp_pkg::lftjp_wcfg_t  cfg_q, cfg_d;
  logic                    tally_mode_q, tally_mode_d;
  logic [15:0]             cnt0_q, cnt0_d, cnt1_q, cnt1_d;
  logic [15:0]             hold0_q, hold0_d, hold1_q, hold1_d;
  logic [31:0]             tround_q, tround_d;
  logic [31:0]             jround_q, jround_d;
  lftjp_pkg::lftjp_peaks_t trk_q, trk_d, res_q, res_d;
  logic [1:0]              stat_q, stat_d, mask_q, mask_d;
  logic [7:0]              rdata_d;

  function automatic logic hit(input logic [10:0] a, input logic [10:0] o);
    hit = (a == o);
  endfunction

  function automatic logic [15:0] inc_sat(input logic [15:0] v);
    inc_sat = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  logic               stop_wr, stop_rise, jit_end, tally_end, snap_wr;
  logic signed [11:0] jit_s;
  logic [11:0]        pos_mag, neg_mag;
  logic               ov0, ov1;

  always_comb begin
    stop_wr  = reg_wr && hit(reg_addr, lftjp_pkg::OFF_WANDER_CFG);
    // edge judged against the stored bit, so rewriting 1 does nothing
    stop_rise = stop_wr && reg_wdata[lftjp_pkg::BIT_STOP] && !cfg_q.stop
                && !cfg_q.period;
    jit_end  = cfg_q.period ? (jround_q >= 32'(JIT_PERIOD - 1))
                            : stop_rise;
    snap_wr  = reg_wr && hit(reg_addr, lftjp_pkg::OFF_TALLY_SNAP);
    tally_end = tally_mode_q ? snap_wr
                             : (tround_q >= 32'(TALLY_ROUND - 1));
    jit_s = cfg_q.bw ? jit_high : jit_wide;
    pos_mag = (jit_s > 12'sd0) ? 12'(jit_s) : 12'h000;
    neg_mag = (jit_s < 12'sd0) ? 12'(-jit_s) : 12'h000;
    ov0 = fault_c0 && (cnt0_q == 16'hFFFF);
    ov1 = fault_c1 && (cnt1_q == 16'hFFFF);
  end

  always_comb begin
    cfg_d        = cfg_q;
    tally_mode_d = tally_mode_q;
    mask_d       = mask_q;
    cnt0_d   = fault_c0 ? inc_sat(cnt0_q) : cnt0_q;
    cnt1_d   = fault_c1 ? inc_sat(cnt1_q) : cnt1_q;
    hold0_d  = hold0_q;
    hold1_d  = hold1_q;
    tround_d = tally_mode_q ? 32'h0000_0000 : tround_q + 32'h0000_0001;
    jround_d = cfg_q.period ? jround_q + 32'h0000_0001 : 32'h0000_0000;
    trk_d    = trk_q;
    res_d    = res_q;
    stat_d   = stat_q;
    if (reg_wr) begin
      if (hit(reg_addr, lftjp_pkg::OFF_WANDER_CFG)) begin
        cfg_d.bw     = reg_wdata[lftjp_pkg::BIT_BW];
        cfg_d.period = reg_wdata[lftjp_pkg::BIT_PERIOD];
        cfg_d.stop   = reg_wdata[lftjp_pkg::BIT_STOP];
      end
      if (hit(reg_addr, lftjp_pkg::OFF_TALLY_CFG))
        tally_mode_d = reg_wdata[lftjp_pkg::BIT_TALLY_MD];
      if (hit(reg_addr, lftjp_pkg::OFF_IRQ_MASK))
        mask_d = reg_wdata[1:0];
    end
    if (tally_end) begin
      hold0_d  = cnt0_q;
      hold1_d  = cnt1_q;
      cnt0_d   = {15'h0000, fault_c0};
      cnt1_d   = {15'h0000, fault_c1};
      tround_d = 32'h0000_0000;
    end
    if (pos_mag > trk_q.pos)
      trk_d.pos = pos_mag;
    if (neg_mag > trk_q.neg)
      trk_d.neg = neg_mag;
    if (jit_end) begin
      res_d = trk_q;
      trk_d = '{pos: pos_mag, neg: neg_mag};
      jround_d = 32'h0000_0000;
    end
    // read clears; a same-cycle overflow still wins
    if (reg_rd && hit(reg_addr, lftjp_pkg::OFF_IRQ_STAT))
      stat_d = 2'h0;
    if (ov1)
      stat_d[lftjp_pkg::BIT_OV_C1] = 1'b1;
    if (ov0)
      stat_d[lftjp_pkg::BIT_OV_C0] = 1'b1;
  end

  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      lftjp_pkg::OFF_TALLY_LO_C1: rdata_d = hold1_q[7:0];
      lftjp_pkg::OFF_TALLY_HI_C1: rdata_d = hold1_q[15:8];
      lftjp_pkg::OFF_TALLY_LO_C0: rdata_d = hold0_q[7:0];
      lftjp_pkg::OFF_TALLY_HI_C0: rdata_d = hold0_q[15:8];
      lftjp_pkg::OFF_WANDER_CFG:
        rdata_d = {5'h00, cfg_q.stop, cfg_q.period, cfg_q.bw};
      lftjp_pkg::OFF_POS_LO:      rdata_d = res_q.pos[7:0];
      lftjp_pkg::OFF_POS_HI:      rdata_d = {4'h0, res_q.pos[11:8]};
      lftjp_pkg::OFF_NEG_LO:      rdata_d = res_q.neg[7:0];
      lftjp_pkg::OFF_NEG_HI:      rdata_d = {4'h0, res_q.neg[11:8]};
      lftjp_pkg::OFF_TALLY_CFG:   rdata_d = {6'h00, tally_mode_q, 1'b0};
      lftjp_pkg::OFF_IRQ_STAT:    rdata_d = {6'h00, stat_q};
      lftjp_pkg::OFF_IRQ_MASK:    rdata_d = {6'h00, mask_q};
      default:                    rdata_d = 8'h00;
    endcase
    if (!reg_rd)
      rdata_d = 8'h00;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q        <= '{stop: 1'b0, period: 1'b0, bw: 1'b0};
      tally_mode_q <= 1'b0;
      cnt0_q       <= lftjp_pkg::RST_TALLY;
      cnt1_q       <= lftjp_pkg::RST_TALLY;
      hold0_q      <= lftjp_pkg::RST_TALLY;
      hold1_q      <= lftjp_pkg::RST_TALLY;
      tround_q     <= 32'h0000_0000;
      jround_q     <= 32'h0000_0000;
      trk_q        <= '{pos: lftjp_pkg::RST_PEAK, neg: lftjp_pkg::RST_PEAK};
      res_q        <= '{pos: lftjp_pkg::RST_PEAK, neg: lftjp_pkg::RST_PEAK};
      stat_q       <= 2'h0;
      mask_q       <= 2'h0;
      reg_rdata    <= lftjp_pkg::RST_BYTE;
    end else if (clk_en) begin
      cfg_q        <= cfg_d;
      tally_mode_q <= tally_mode_d;
      cnt0_q       <= cnt0_d;
      cnt1_q       <= cnt1_d;
      hold0_q      <= hold0_d;
      hold1_q      <= hold1_d;
      tround_q     <= tround_d;
      jround_q     <= jround_d;
      trk_q        <= trk_d;
      res_q        <= res_d;
      stat_q       <= stat_d;
      mask_q       <= mask_d;
      reg_rdata    <= rdata_d;
    end
  end

  // e1_mode only moves the band edges in the analog front end
  assign bandwidth_select = cfg_q.bw;
  assign irq = |(stat_q & mask_q);
endmodule // lftjp_core

// file: sim/lftjp_core_sva.sv
// port assertions for the fault tally and jitter peak block
// assumes clk_en held high whenever registers are accessed
`timescale 1ns/1ps
module lftjp_sva (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  input wire logic [10:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        bandwidth_select,
  input wire logic        irq
);
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  always_comb begin
    mask_d = mask_q;
    if (clk_en && reg_wr && reg_addr == 11'h7F3) mask_d = reg_wdata[1:0];
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) mask_q <= 2'h0;
    else mask_q <= mask_d;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr(a); clk_en && reg_wr && reg_addr == a; endsequence
  sequence s_rd(a); clk_en && reg_rd && reg_addr == a; endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_cfg_readback: assert property (s_wr(11'h7E5) ##2 s_rd(11'h7E5)
    |=> reg_rdata == ($past(reg_wdata, 3) & 8'h07)) else $error("cfg readback");
  a_mask_readback: assert property (s_wr(11'h7F3) ##2 s_rd(11'h7F3)
    |=> ((reg_rdata ^ $past(reg_wdata, 3)) & 8'h03) == 8'h00)
    else $error("mask readback");
  a_bw_follows: assert property (s_wr(11'h7E5)
    |=> bandwidth_select == $past(reg_wdata[0])) else $error("bandwidth");
  a_peak_nibble: assert property (s_rd(11'h7E7) or s_rd(11'h7E9)
    |=> reg_rdata[7:4] == 4'h0) else $error("reserved nibble set");
  a_unmapped_zero: assert property (s_rd(11'h100)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_masked_quiet: assert property (s_wr(11'h7F3) ##0 reg_wdata[1:0] == 2'h0
    |-> ##2 !irq) else $error("irq with mask cleared");
  a_irq_masked: assert property (irq |-> (mask_q | $past(mask_q)) != 2'h0)
    else $error("irq without mask bit");
endmodule // lftjp_sva
bind lftjp_core lftjp_sva u_sva (.sys_clk, .arst_n, .clk_en, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bandwidth_select, .irq);

// file: sim/test_line_fault_tally_and_jitter_peaks.sv
// self-checking bench for the fault tally and jitter peak block
// assumes short round parameters; clk_en held high except for one frozen write
`timescale 1ns/1ps
module test_line_fault_tally_and_jitter_peaks;
  logic               sys_clk = 1'b0;
  logic               arst_n = 1'b0;
  logic [10:0]        reg_addr = 11'h000;
  logic [7:0]         reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [7:0]         reg_rdata;
  logic [1:0]         flt = 2'h0;
  logic               e1 = 1'b0;
  logic signed [11:0] jw = 12'sh000;
  logic signed [11:0] jh = 12'sh000;
  logic               bw;
  logic               irq;
  logic               rd_pend = 1'b0;
  logic               ce = 1'b1;
  logic [7:0]         exp_q[$];
  int                 n_errors = 0;
  int                 comparisons = 0;
  int                 cyc = 0;
  logic [10:0] ra[10] = '{11'h023, 11'h024, 11'h7E3, 11'h7E4, 11'h7E5,
    11'h7E6, 11'h7E7, 11'h7E8, 11'h7E9, 11'h100};
  always #5 sys_clk = ~sys_clk;
  lftjp_core #(.TALLY_ROUND(100), .JIT_PERIOD(100)) dut (.sys_clk(sys_clk),
    .arst_n(arst_n), .clk_en(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fault_c0(flt[0]), .fault_c1(flt[1]),
    .e1_mode(e1), .jit_wide(jw), .jit_high(jh),
    .bandwidth_select(bw), .irq(irq));
  task automatic close_out();
    $display("%0d mismatches in %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(logic [7:0] seen, logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // one idle cycle after each strobe keeps drivers single-assigned
  task automatic wr(logic [10:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(logic [10:0] a, logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (rd_pend) check(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic tally();
    logic [1:0]  f;
    logic [15:0] c0;
    logic [15:0] c1;
    c0 = 16'h0000;
    c1 = 16'h0000;
    repeat (30) begin
      f = 2'($urandom);
      flt <= f;
      c0 += 16'(f[0]);
      c1 += 16'(f[1]);
      @(posedge sys_clk);
    end
    flt <= 2'h0;
    wr(11'h7F1, 8'h01);
    rd(11'h023, c1[7:0]);
    rd(11'h024, c1[15:8]);
    rd(11'h7E3, c0[7:0]);
    rd(11'h7E4, c0[15:8]);
  endtask
  task automatic jit(logic b);
    int v;
    int p;
    int n;
    p = 0;
    n = 0;
    e1 <= b;
    if (b) jw <= 12'sh7FF;
    else jh <= 12'sh7FF;
    wr(11'h7E5, {7'h00, b});
    rd(11'h7E5, {7'h00, b});
    wr(11'h7E5, {5'h00, 2'h2, b});
    wr(11'h7E5, {7'h00, b});
    repeat (20) begin
      v = int'($urandom_range(4094)) - 2047;
      if (v > p) p = v;
      if (-v > n) n = -v;
      if (b) jh <= 12'(v);
      else jw <= 12'(v);
      @(posedge sys_clk);
    end
    jw <= 12'sh000;
    jh <= 12'sh000;
    wr(11'h7E5, {5'h00, 2'h2, b});
    rd(11'h7E6, p[7:0]);
    rd(11'h7E7, {4'h0, p[11:8]});
    rd(11'h7E8, n[7:0]);
    rd(11'h7E9, {4'h0, n[11:8]});
    check({7'h00, bw}, {7'h00, b});
  endtask
  initial begin
    void'($urandom(67));
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    wr(11'h7E6, 8'hFF);
    foreach (ra[i]) rd(ra[i], 8'h00);
    $display("reset values done");
    wr(11'h7F0, 8'h02);
    tally();
    tally();
    $display("tally done");
    jit(1'b0);
    jit(1'b1);
    jw <= 12'sh005;
    wr(11'h7E5, 8'h02);
    repeat (250) @(posedge sys_clk);
    rd(11'h7E6, 8'h05);
    $display("jitter done");
    wr(11'h7F3, 8'h00);
    flt <= 2'h2;
    repeat (65540) @(posedge sys_clk);
    flt <= 2'h0;
    check({7'h00, irq}, 8'h00);
    wr(11'h7F3, 8'h01);
    rd(11'h7F3, 8'h01);
    check({7'h00, irq}, 8'h01);
    rd(11'h7F2, 8'h01);
    rd(11'h7F2, 8'h00);
    check({7'h00, irq}, 8'h00);
    wr(11'h7F1, 8'h01);
    rd(11'h023, 8'hFF);
    rd(11'h024, 8'hFF);
    // write while frozen must not land
    ce <= 1'b0;
    wr(11'h7F3, 8'h00);
    ce <= 1'b1;
    rd(11'h7F3, 8'h01);
    $display("overflow done");
    repeat (2) @(posedge sys_clk);
    close_out();
  end
endmodule // test_line_fault_tally_and_jitter_peaks
